/* File: rtl/lsl16_core.sv */
// 16-bit serial-in LED sink driver: shift chain, output latch, open-drain sinks.
// Assumes pins are asynchronous; strobes slower than a few system clocks.
`timescale 1ns/1ps
`include "lsl16_defs.svh"

// What this block does
// R1: Sixteen shift stages feed a sixteen-bit latch.
// R2: Per bit, shift stage and latch stage.
// R3: Act only on rising strobe edges.
// R4: Serial enters stage one, shifts each strobe.
// R5: Input inverted on entry; high lights LED.
// R6: Latch strobe copies shift contents to outputs.
// R7: Outputs sink low or float, never high.
// R8: Cascade output presents the last stage, inverted.
// R9: Tied strobes give one-strobe-delayed outputs.
// R10: Reset sets registers, floats outputs, cascade low.
// R11: Reset acts asynchronously, needs no strobe.
// R12: Disable floats outputs, cascade keeps driving.
// R13: Disable never disturbs shifting.
// R14: Host latches only after intended shift.
// R15: Host sends sixteen bits, last first, then latch.

module lsl16_core
(
    input  wire logic               clk_sys_i,
    input  wire logic               rstn_i,
    input  wire logic               ce_i,
    input  wire logic               serial_in_i,
    input  wire logic               shift_strobe_i,
    input  wire logic               latch_strobe_i,
    input  wire logic               out_disable_i,
    output lsl16_pkg::lsl16_word_t  led_sink_outputs_o,
    output lsl16_pkg::lsl16_word_t  led_sink_outputs_oe_o,
    output logic                    cascade_out_o
);
    import lsl16_pkg::*;

    lsl16_pins_s pin_lvl;
    lsl16_pins_s pin_rise;
    // R1: sixteen stages, one latch
    lsl16_word_t stage_q;
    lsl16_word_t stage_d;
    lsl16_word_t latch_q;
    lsl16_word_t latch_d;
    lsl16_sink_s sink_q;
    lsl16_sink_s sink_d;
    logic        cascade_q;
    logic        cascade_d;
    logic        shift_ev;
    logic        latch_ev;

    // R3: edge detect
    lsl16_sync_edge #(
        .WIDTH ($bits(lsl16_pins_s))
    ) u_pins (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .ce_i      (ce_i),
        .async_i   ({serial_in_i, shift_strobe_i, latch_strobe_i, out_disable_i}),
        .level_o   (pin_lvl),
        .rise_o    (pin_rise)
    );

    assign shift_ev = pin_rise.shift;
    assign latch_ev = pin_rise.latch;

    always_comb
    begin
        stage_d = stage_q;
        latch_d = latch_q;
        // R4: shift one stage
        // R5: invert on entry
        // R13: disable not involved
        if (shift_ev)
        begin
            stage_d = {stage_q[`LSL16_LAST-1:0], ~pin_lvl.serial};
        end
        // R6: copy pre-shift contents
        // R9: same-edge latch sees old chain
        if (latch_ev)
        begin
            latch_d = stage_q;
        end
        // R8: cascade from last stage
        cascade_d = ~stage_d[`LSL16_LAST];
        // R7: only ever sink low
        sink_d.level = `LSL16_SINK_LEVEL;
        // R12: disable floats sinks
        sink_d.oe = pin_lvl.disable_out ? `LSL16_OE_RST : ~latch_d;
    end

    // R2: separate shift and latch flops
    // R10: reset sets both registers
    // R11: asynchronous reset
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            stage_q   <= `LSL16_STAGE_RST;
            latch_q   <= `LSL16_STAGE_RST;
            sink_q    <= {`LSL16_SINK_LEVEL, `LSL16_OE_RST};
            cascade_q <= `LSL16_CASC_RST;
        end
        else if (ce_i)
        begin
            stage_q   <= stage_d;
            latch_q   <= latch_d;
            sink_q    <= sink_d;
            cascade_q <= cascade_d;
        end
    end

    assign led_sink_outputs_o    = sink_q.level;
    assign led_sink_outputs_oe_o = sink_q.oe;
    assign cascade_out_o         = cascade_q;

    // R4: entry into stage one
    chk_shift_entry: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R5
        shift_ev && ce_i |=> stage_q[0] == ~$past(pin_lvl.serial))
        else $error("serial bit not stored inverted");

    // R4: chain moves once
    chk_shift_move: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R4
        shift_ev && ce_i |=> stage_q[`LSL16_LAST:1] == $past(stage_q[`LSL16_LAST-1:0]))
        else $error("chain did not move one stage");

    // R3: chain needs edge
    chk_shift_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R3
        !shift_ev |=> $stable(stage_q))
        else $error("chain changed without rising shift strobe");

    // R6: latch copies chain
    chk_latch_copy: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R6
        latch_ev && ce_i |=> latch_q == $past(stage_q))
        else $error("latch did not take chain contents");

    // R9: latch holds between strobes
    chk_latch_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R9
        !latch_ev ##1 !latch_ev |-> $stable(latch_q))
        else $error("latch changed without rising latch strobe");

    // R7: never drive high
    chk_never_high: assert property (@(posedge clk_sys_i) // R7
        led_sink_outputs_o == `LSL16_SINK_LEVEL)
        else $error("sink output driven high");

    // R8: cascade follows tail
    chk_cascade_tail: assert property (@(posedge clk_sys_i) // R8
        cascade_out_o == ~stage_q[`LSL16_LAST])
        else $error("cascade does not follow last stage");

    // R12: disable floats sinks
    chk_disable_float: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R12
        pin_lvl.disable_out && ce_i |=> led_sink_outputs_oe_o == `LSL16_OE_RST)
        else $error("sinks driven while disabled");

    // R6: sinks follow latch
    chk_sink_follow: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R6
        !pin_lvl.disable_out && ce_i |=> led_sink_outputs_oe_o == ~latch_q)
        else $error("sink enables do not follow latch");

    // R10: reset state held
    chk_reset_state: assert property (@(posedge clk_sys_i) // R10
        !rstn_i |-> stage_q == `LSL16_STAGE_RST && latch_q == `LSL16_STAGE_RST
                    && led_sink_outputs_oe_o == `LSL16_OE_RST && !cascade_out_o)
        else $error("reset state wrong");

    // R3: one cycle events
    chk_shift_pulse: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R3
        shift_ev |=> !shift_ev)
        else $error("shift event lasted more than one cycle");

    // R3: one cycle events
    chk_latch_pulse: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R3
        latch_ev |=> !latch_ev)
        else $error("latch event lasted more than one cycle");

    // R3: latch needs edge
    chk_latch_quiet: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R3
        !latch_ev |=> $stable(latch_q))
        else $error("latch changed without latch event");

    // R2: latch leaves chain
    chk_latch_only: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R2
        latch_ev && !shift_ev |=> $stable(stage_q))
        else $error("latch strobe moved the chain");

    // R2: shift leaves latch
    chk_shift_only: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R2
        shift_ev && !latch_ev |=> $stable(latch_q))
        else $error("shift strobe changed the latch");

    // R9: tied strobes, old chain
    chk_tied_delay: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R9
        shift_ev && latch_ev |=> latch_q == $past(stage_q)
                                && stage_q[0] == ~$past(pin_lvl.serial))
        else $error("tied strobes did not latch the old chain");

    // R13: disable keeps shifting
    chk_disable_shift: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R13
        shift_ev && pin_lvl.disable_out
        |=> stage_q[`LSL16_LAST:1] == $past(stage_q[`LSL16_LAST-1:0]))
        else $error("chain stalled while sinks disabled");

    // R12: cascade still driven
    chk_cascade_disable: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R12
        pin_lvl.disable_out |=> cascade_out_o == ~stage_q[`LSL16_LAST])
        else $error("cascade lost while sinks disabled");

    // R8: cascade shows new tail
    chk_cascade_shift: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R8
        shift_ev |=> cascade_out_o == ~$past(stage_q[`LSL16_LAST-1]))
        else $error("cascade did not take the next-to-last stage");

    // R6: sinks show latched chain
    chk_latch_drive: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // R6
        latch_ev && !pin_lvl.disable_out |=> led_sink_outputs_oe_o == ~$past(stage_q))
        else $error("sinks do not show the latched chain");

    // R10: state held at release
    chk_release_state: assert property (@(posedge clk_sys_i) // R10
        $rose(rstn_i) |-> stage_q == `LSL16_STAGE_RST && latch_q == `LSL16_STAGE_RST
                          && led_sink_outputs_oe_o == `LSL16_OE_RST && !cascade_out_o)
        else $error("reset state lost at release");

endmodule // lsl16_core

/* File: rtl/lsl16_defs.svh */
// Constants for the 16-bit LED sink shift/latch block.
// Assumes inclusion by bare name from files under rtl/.
`ifndef LSL16_DEFS_SVH
`define LSL16_DEFS_SVH

`define LSL16_WIDTH      16
`define LSL16_LAST       15
`define LSL16_STAGE_RST  16'hffff
`define LSL16_OE_RST     16'h0000
`define LSL16_CASC_RST   1'b0
`define LSL16_SINK_LEVEL 16'h0000
`define LSL16_PIN_COUNT  4

`endif

/* File: rtl/lsl16_pkg.sv */
// Types for the 16-bit LED sink shift/latch block.
// Assumes lsl16_defs.svh is on the include path.
`include "lsl16_defs.svh"

package lsl16_pkg;

    typedef logic [`LSL16_WIDTH-1:0] lsl16_word_t;

    // Pin group as seen after synchronisation
    typedef struct packed {
        logic serial;
        logic shift;
        logic latch;
        logic disable_out;
    } lsl16_pins_s;

    // Open-drain sink group: level driven and enable per output
    typedef struct packed {
        lsl16_word_t level;
        lsl16_word_t oe;
    } lsl16_sink_s;

endpackage

/* File: rtl/lsl16_sync_edge.sv */
// Two-flop synchroniser with rising-edge detector, any width.
// Assumes inputs are asynchronous to clk_sys_i.
`timescale 1ns/1ps

module lsl16_sync_edge #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rstn_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] level_o,
    output logic      [WIDTH-1:0] rise_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;
    logic [WIDTH-1:0] prev_q;
    logic [WIDTH-1:0] prev_d;

    always_comb
    begin
        meta_d = meta_q;
        sync_d = sync_q;
        prev_d = prev_q;
        if (ce_i)
        begin
            meta_d = async_i;
            sync_d = meta_q;
            prev_d = sync_q;
        end
    end

    // First stage feeds only the second one
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    assign level_o = sync_q;
    assign rise_o  = sync_q & ~prev_q & {WIDTH{ce_i}};

endmodule // lsl16_sync_edge

/* File: verif/lsl16_host.sv */
// Host model: serial data and the two strobes.
// Assumes the bench clock; pins move on falling edges.
`timescale 1ns/1ps

module lsl16_host (
    input  wire logic clk_i,
    output logic      serial_o,
    output logic      shift_o,
    output logic      latch_o
);
    initial
    begin
        serial_o = 1'b0;
        shift_o = 1'b0;
        latch_o = 1'b0;
    end

    // data settles, then strobes
    // Setup of 30 ns kept so no shift samples moving data
    task automatic pulse(input logic d, input logic s, input logic l);
        serial_o = d;
        repeat (3) @(negedge clk_i);
        shift_o = s;
        latch_o = l;
        repeat (6) @(negedge clk_i);
        shift_o = 1'b0;
        latch_o = 1'b0;
        repeat (4) @(negedge clk_i);
    endtask
endmodule // lsl16_host

/* File: verif/testbench.sv */
// Bench: host model drives pins, integer model predicts outputs.
// Assumes lsl16_core and lsl16_host; 100 MHz clock.
`timescale 1ns/1ps

module testbench;
    import lsl16_pkg::*;
    // Clock starts high so reset falls before the first rising edge
    logic        clk_sys_i = 1'b1;
    logic        rstn_i = 1'b1;
    logic        ce;
    logic        dis;
    logic        ser;
    logic        shf;
    logic        lat;
    logic        casc;
    lsl16_word_t lvl;
    lsl16_word_t oe;
    int          err_count;
    int          check_count;
    int          sh;
    int          lq;
    int          d;

    lsl16_host host (.clk_i(clk_sys_i), .serial_o(ser), .shift_o(shf), .latch_o(lat));

    lsl16_core uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce),
        .serial_in_i(ser), .shift_strobe_i(shf), .latch_strobe_i(lat),
        .out_disable_i(dis), .led_sink_outputs_o(lvl),
        .led_sink_outputs_oe_o(oe), .cascade_out_o(casc));

    initial
    begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Latch takes the pre-shift chain when strobes coincide
    task automatic step(input int v, input logic s, input logic l);
        if (l)
            lq = sh;
        if (s)
            sh = {sh[14:0], ~v[0]};
        host.pulse(v[0], s, l);
        chk(lvl, 16'h0000);
        chk(oe, dis ? 16'h0000 : ~lq[15:0]);
        chk({15'h0, casc}, {15'h0, ~sh[15]});
    endtask

    task automatic do_reset();
        @(negedge clk_sys_i);
        rstn_i = 1'b0;
        #1;
        chk(oe, 16'h0000);
        chk({15'h0, casc}, 16'h0000);
        repeat (4) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        sh = 16'hffff;
        lq = 16'hffff;
        repeat (4) @(negedge clk_sys_i);
    endtask

    initial
    begin
        dis = 1'b0;
        ce = 1'b1;
        err_count = 0;
        check_count = 0;
        d = $urandom(26331);
        do_reset();
        repeat (3)
        begin
            d = $urandom;
            for (int i = 0; i < 16; i++)
                step(d >> (15 - i), 1'b1, 1'b0);
            step(0, 1'b0, 1'b1);
            chk(oe, d[15:0]);
        end
        step($urandom, 1'b0, 1'b0);
        dis = 1'b1;
        for (int i = 0; i < 20; i++)
            step($urandom, 1'b1, i[0]);
        dis = 1'b0;
        step(1, 1'b0, 1'b1);
        for (int i = 0; i < 8; i++)
            step($urandom, 1'b1, 1'b1);
        // Frozen block must miss a whole strobe pulse
        ce = 1'b0;
        host.pulse(1'b1, 1'b1, 1'b1);
        ce = 1'b1;
        chk(oe, ~lq[15:0]);
        chk({15'h0, casc}, {15'h0, ~sh[15]});
        step(0, 1'b0, 1'b1);
        do_reset();
        for (int i = 0; i < 4; i++)
            step($urandom, 1'b1, 1'b0);
        give_verdict();
    end

    // Whole run is near 11.5 us; a hang stops here
    initial
    begin
        #100us;
        err_count++;
        give_verdict();
    end
endmodule // testbench
